/* File: dv/i2c_host_model.sv */
/* behavioural i2c bus controller.
   assumes the bench builds a pulled-up sda wire. */
`timescale 1ns/1ps
module i2c_host_model (
  // bus
  output logic    scl,
  output logic    sda_drv,
  input wire logic sda
);
  // ---------------
  // bit timing
  // ---------------
  // quarter bit; scaled down to keep the run short
  localparam int Q = 40;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task start_bit;
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start_bit
  task stop_bit;
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #Q;
  endtask : stop_bit
  task bit_x(input logic b, output logic q);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q q = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bit_x
  // last high releases sda for the ack slot
  task byte_x(input logic [7:0] o, input logic last, output logic [7:0] i, output logic ack);
    logic a;
    for (int k = 7; k >= 0; k--) bit_x(o[k], i[k]);
    bit_x(last, a);
    ack = ~a;
  endtask : byte_x
endmodule : i2c_host_model

/* File: dv/i2c_ptr_target_checker.sv */
/* port checker for i2c_ptr_target.
   assumes it is bound onto every target instance. */
`timescale 1ns/1ps
module i2c_ptr_target_checker (
  // system
  input wire logic clock,
  input wire logic rst_n,
  // bus pins
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // register side
  input wire i2c_ptr_pkg::reg_access_s wr_access,
  input wire logic wr_strobe,
  input wire logic [7:0] rd_addr,
  input wire logic busy
);
  // ---------------
  // properties
  // ---------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // pointer follows the written register, wrapping at the top
  sequence s_step;
    ##[0:2] rd_addr == wr_access.addr + 8'h01;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n && !wr_strobe && rd_addr == 8'h00)
    else $error("outputs not at reset values");
  a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe wider than one cycle");
  a_ptr_step: assert property (wr_strobe |-> s_step)
    else $error("pointer did not step after a write");
  a_ptr_quiet: assert property (!busy && !$past(busy) |-> $stable(rd_addr))
    else $error("pointer moved outside a transfer");
  a_strobe_busy: assert property (wr_strobe |-> busy)
    else $error("register write outside a transfer");
  a_idle_release: assert property (!busy |-> sda_oe_n)
    else $error("sda pulled while idle");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("sda changed while scl high");
  a_access_hold: assert property ($changed(wr_access) |-> wr_strobe)
    else $error("write record changed without strobe");
  a_out_low: assert property ($past(rst_n) |-> !sda_out)
    else $error("sda output level not low");
endmodule : i2c_ptr_target_checker

bind i2c_ptr_target i2c_ptr_target_checker u_chk (.clock(clock), .rst_n(rst_n), .scl(scl),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_access(wr_access), .wr_strobe(wr_strobe),
  .rd_addr(rd_addr), .busy(busy));

/* File: dv/tb_i2c_ptr_target.sv */
/* testbench for i2c_ptr_target.
   assumes the host model and a pulled-up sda. */
`timescale 1ns/1ps
module tb_i2c_ptr_target;
  import i2c_ptr_pkg::*;
  // ---------------
  // setup
  // ---------------
  logic clock, rst_n, scl, sda_drv, sda_out, sda_oe_n, wr_strobe, busy, ack;
  logic [7:0] rd_addr, d;
  logic [7:0] mem [256];
  reg_access_s wr_access;
  reg_access_s wlog [$];
  int err_count, checks_done;
  wire sda = sda_drv & (sda_oe_n | sda_out);
  wire [7:0] rd_data = mem[rd_addr];
  i2c_ptr_target dut (.clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wr_access(wr_access), .wr_strobe(wr_strobe), .rd_addr(rd_addr),
    .rd_data(rd_data), .busy(busy));
  i2c_host_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (wr_strobe === 1'b1) begin
    mem[wr_access.addr] <= wr_access.data;
    wlog.push_back(wr_access);
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] b);
    host.byte_x(b, 1'b1, d, ack);
    chk("ack", 16'h0001, {15'h0, ack});
  endtask : wr
  // ---------------
  // scenarios
  // ---------------
  task t_write;
    wlog.delete();
    host.start_bit();
    wr(8'h64);
    wr(8'h88);
    chk("busy", 16'h0001, {15'h0, busy});
    for (int k = 0; k < 4; k++) wr(8'hA0 + k[7:0]);
    host.stop_bit();
    for (int k = 0; k < 4; k++) chk("wr", {8'h88 + k[7:0], 8'hA0 + k[7:0]}, wlog[k]);
    chk("ptr", 16'h008C, {8'h00, rd_addr});
    $display("test write done");
  endtask : t_write
  task t_read;
    host.start_bit();
    wr(8'h64);
    wr(8'h88);
    host.start_bit();
    wr(8'h65);
    for (int k = 0; k < 4; k++) begin
      host.byte_x(8'hFF, k == 3, d, ack);
      chk("rd", {8'h00, 8'hA0 + k[7:0]}, {8'h00, d});
    end
    host.stop_bit();
    chk("ptr", 16'h008C, {8'h00, rd_addr});
    $display("test read done");
  endtask : t_read
  task t_wrap;
    wlog.delete();
    host.start_bit();
    wr(8'h64);
    wr(8'hFF);
    wr(8'h11);
    wr(8'h22);
    host.stop_bit();
    chk("wr", 16'hFF11, wlog[0]);
    chk("wr", 16'h0022, wlog[1]);
    chk("ptr", 16'h0001, {8'h00, rd_addr});
    $display("test wrap done");
  endtask : t_wrap
  task t_other;
    wlog.delete();
    host.start_bit();
    host.byte_x(8'h66, 1'b1, d, ack);
    chk("ack", 16'h0000, {15'h0, ack});
    host.byte_x(8'h10, 1'b1, d, ack);
    host.stop_bit();
    repeat (4) @(negedge clock);
    chk("busy", 16'h0000, {15'h0, busy});
    chk("ptr", 16'h0001, {8'h00, rd_addr});
    chk("writes", 16'h0000, 16'(wlog.size()));
    $display("test other address done");
  endtask : t_other
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    t_write;
    t_read;
    t_wrap;
    t_other;
    wrap_up;
  end
  // 19 bytes of 1.44 us each, with ample margin
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
endmodule : tb_i2c_ptr_target

/* File: hw/i2c_ptr_pkg.sv */
/*
  package for the i2c register pointer target: address, timing figures,
  link structs and pin sampler depth. assumes a 100 MHz system clock.
*/
package i2c_ptr_pkg;

  localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h32;
  localparam logic [7:0] PTR_RESET           = 8'h00;
  localparam logic [7:0] PTR_STEP            = 8'h01;
  localparam int         SYNC_STAGES         = 3;
  localparam logic [2:0] BIT_LAST            = 3'h7;
  localparam logic [2:0] BIT_FIRST           = 3'h0;

  // clock and bus figures
  localparam int CLK_PERIOD_NS     = 10;
  localparam int FSCL_FAST_KHZ     = 400;
  localparam int FSCL_STD_KHZ      = 100;
  // shortest scl phase the target must resolve (fast mode, about 1.25 us)
  localparam int SCL_MIN_PHASE_NS  = 1000000 / FSCL_FAST_KHZ / 2;
  localparam int SCL_MIN_PHASE_CYC = SCL_MIN_PHASE_NS / CLK_PERIOD_NS;

  // sampled pin levels
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  // data seen at the register side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_access_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WRX   = 3'b011,
    ST_WACK  = 3'b100,
    ST_RTX   = 3'b101,
    ST_RACK  = 3'b110
  } link_state_e;

endpackage : i2c_ptr_pkg

/* File: hw/i2c_ptr_target.sv */
/*
  i2c target with an 8-bit register address pointer in front of a byte-wide
  register space. the register space itself sits outside: a write strobe
  with address and data, and a combinational read data input.
  assumes a 100 MHz clock, scl and sda as raw pins, open-drain sda.
*/
`timescale 1ns/1ps
module i2c_ptr_target #(
  parameter logic [6:0] TARGET_ADDR = i2c_ptr_pkg::DEFAULT_TARGET_ADDR
) (
  // system
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // bus pins
  input  wire logic                    scl,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  // register space
  output i2c_ptr_pkg::reg_access_s     wr_access,
  output logic                         wr_strobe,
  output logic [7:0]                   rd_addr,
  input  wire logic [7:0]              rd_data,
  // status
  output logic                         busy
);
  import i2c_ptr_pkg::*;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  bus_pins_s raw, pins, pins_d;
  assign raw.scl = scl;
  assign raw.sda = sda_in;

  // sampling at 100 MHz leaves many samples per fast-mode phase
  pin_sync3 u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .raw   (raw),
    .clean (pins)
  );

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise   = pins.scl & ~pins_d.scl;
  assign scl_fall   = ~pins.scl & pins_d.scl;
  assign start_seen = pins.scl & pins_d.scl & pins_d.sda & ~pins.sda;
  assign stop_seen  = pins.scl & pins_d.scl & ~pins_d.sda & pins.sda;

  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    ptr_step = p + PTR_STEP;
  endfunction : ptr_step

  // ----------------------------------------
  // link state
  // ----------------------------------------
  link_state_e state, next_state;
  logic [7:0]  shreg, next_shreg;
  logic [2:0]  bitn, next_bitn;
  logic [7:0]  ptr, next_ptr;
  logic        first, next_first;
  logic        byte_done, next_byte_done;
  logic        drive_low, next_drive_low;
  logic        next_wr_strobe, next_busy;
  reg_access_s next_wr_access;

  always_comb begin
    next_state      = state;
    next_shreg      = shreg;
    next_bitn       = bitn;
    next_ptr        = ptr;
    next_first      = first;
    next_byte_done  = byte_done;
    next_drive_low  = drive_low;
    next_wr_strobe  = 1'b0;
    next_wr_access  = wr_access;
    next_busy       = (state != ST_IDLE);
    if (start_seen) begin
      // repeated start keeps the pointer for a following read
      next_state     = ST_ADDR;
      next_bitn      = BIT_FIRST;
      next_byte_done = 1'b0;
      next_drive_low = 1'b0;
    end else if (stop_seen) begin
      next_state     = ST_IDLE;
      next_byte_done = 1'b0;
      next_drive_low = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_drive_low = 1'b0;
        end
        ST_ADDR, ST_WRX: begin
          if (scl_rise) begin
            next_shreg     = {shreg[6:0], pins.sda};
            next_bitn      = bitn + 3'h1;
            // bit counter wraps to zero, so a flag marks the full byte
            next_byte_done = (bitn == BIT_LAST);
          end
          // the fall right after a start must not close an empty byte
          if (scl_fall && byte_done) begin
            next_byte_done = 1'b0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == TARGET_ADDR) begin
                next_state     = ST_AACK;
                next_drive_low = 1'b1;
                next_first     = 1'b1;
              end else begin
                next_state = ST_IDLE;
              end
            end else begin
              next_state     = ST_WACK;
              next_drive_low = 1'b1;
              if (first) begin
                next_ptr   = shreg;
                next_first = 1'b0;
              end else begin
                next_wr_strobe      = 1'b1;
                next_wr_access.addr = ptr;
                next_wr_access.data = shreg;
                next_ptr            = ptr_step(ptr);
              end
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (shreg[0]) begin
              next_state     = ST_RTX;
              next_shreg     = rd_data;
              next_drive_low = ~rd_data[7];
              next_bitn      = BIT_FIRST;
            end else begin
              next_state     = ST_WRX;
              next_drive_low = 1'b0;
              next_bitn      = BIT_FIRST;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            next_state     = ST_WRX;
            next_drive_low = 1'b0;
          end
        end
        ST_RTX: begin
          if (scl_fall) begin
            if (bitn == BIT_LAST) begin
              next_state     = ST_RACK;
              next_drive_low = 1'b0;
              next_ptr       = ptr_step(ptr);
            end else begin
              next_shreg     = {shreg[6:0], 1'b0};
              next_drive_low = ~shreg[6];
              next_bitn      = bitn + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            next_first = pins.sda;
          end
          if (scl_fall) begin
            if (first) begin
              next_state = ST_IDLE; // nack ends the read
            end else begin
              next_state     = ST_RTX;
              next_shreg     = rd_data;
              next_drive_low = ~rd_data[7];
              next_bitn      = BIT_FIRST;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_d    <= '1;
      state     <= ST_IDLE;
      shreg     <= 8'h00;
      bitn      <= BIT_FIRST;
      ptr       <= PTR_RESET;
      first     <= 1'b0;
      byte_done <= 1'b0;
      drive_low <= 1'b0;
      wr_strobe <= 1'b0;
      wr_access <= '0;
      busy      <= 1'b0;
      sda_out   <= 1'b1;
      sda_oe_n  <= 1'b1;
      rd_addr   <= PTR_RESET;
    end else begin
      pins_d    <= pins;
      state     <= next_state;
      shreg     <= next_shreg;
      bitn      <= next_bitn;
      ptr       <= next_ptr;
      first     <= next_first;
      byte_done <= next_byte_done;
      drive_low <= next_drive_low;
      wr_strobe <= next_wr_strobe;
      wr_access <= next_wr_access;
      busy      <= next_busy;
      // open drain: only ever pull low
      sda_out   <= 1'b0;
      sda_oe_n  <= ~next_drive_low;
      rd_addr   <= next_ptr;
    end
  end

endmodule : i2c_ptr_target

/* File: hw/pin_sync3.sv */
/*
  three-stage synchroniser for the scl and sda pins with agreement check.
  assumes pins are asynchronous to clock.
*/
`timescale 1ns/1ps
module pin_sync3 (
  // system
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // pins in, clean levels out
  input  wire i2c_ptr_pkg::bus_pins_s raw,
  output i2c_ptr_pkg::bus_pins_s      clean
);
  import i2c_ptr_pkg::*;

  bus_pins_s s1, s2, s3, next_clean;

  // idle bus is high on both lines
  always_comb begin
    next_clean.scl = (s2.scl == s3.scl) ? s3.scl : clean.scl;
    next_clean.sda = (s2.sda == s3.sda) ? s3.sda : clean.sda;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1    <= '1;
      s2    <= '1;
      s3    <= '1;
      clean <= '1;
    end else begin
      s1    <= raw;
      s2    <= s1;
      s3    <= s2;
      clean <= next_clean;
    end
  end

endmodule : pin_sync3
